// file: audio_path_gain_routing_regs.sv
// audio path control/status bank with active-gain tracking and clip guard
// assumes a decoded 8-bit register port and level samples on clk
`timescale 1ns/100ps

// Behaviour
// - clip guard enable bit seven, reset off
// - clip attack rate doubles per step code
// - clip threshold is (x+1)/128 full scale
// - read-only offset correction bits fifteen to eight
// - read-only offset correction bits nineteen to sixteen
// - mic gain code, status shows active
// - input mixer gain code and status
// - adc status reports active gain code
// - dac codes below eight mute
// - phones status reports active six-bit gain
// - mic source select, code three reserved
// - midrail charge mode bit four, slow reset
// - master bias bit three gates analog paths
// - input mixer connects mic when set and mix enable bit three of the mixer control is set
// - adc gain seven bits, reset 0x6F
// - dac gains seven bits, reset 0x6F
// - phones gains six bits, reset 0x39
// - output mixer routes its dac channel
// - mic gain three bits, reset one
// - level control enable gates clip guard changes, not the gain ramp
module audio_path_gain_routing_regs
   import audio_regs_pkg::*;
#(
   parameter int LEVEL_W = 16  // width of the level magnitude sample
) (
   input  wire logic                         clk,          // system clock
   input  wire logic                         rst,          // async reset
   input  wire logic                         ce,           // clock enable
   input  wire logic                         wr_en,        // write strobe
   input  wire logic                         rd_en,        // read strobe
   input  wire logic [audio_regs_pkg::ADDR_W-1:0] addr,    // register
   input  wire logic [audio_regs_pkg::DATA_W-1:0] wdata,   // write data
   output logic      [audio_regs_pkg::DATA_W-1:0] rdata,   // read data
   output logic                              rvalid,       // read done
   input  wire logic                         sample_tick,  // one per Fs
   input  wire logic [LEVEL_W-1:0]           adc_level,    // |output|
   input  wire logic [19:0]                  offset_value, // dc offset
   output audio_regs_pkg::analog_ctrl_s      ctl           // to analog
);
   import audio_regs_pkg::*;

   typedef struct packed {
      logic [NRW:0][7:0]      rw;
      logic [NACT-1:0][6:0]   act;
      logic [6:0]             clip_atten;
      logic [4:0]             clip_acc;
      logic [19:0]            ofs;
      logic [7:0]             rdata;
      logic                   rvalid;
      analog_ctrl_s           ctl;
   } state_s;

   state_s state_ff;
   state_s nxt_state;

   function automatic logic [6:0] step_to(input logic [6:0] cur,
                                          input logic [6:0] tgt);
      logic [6:0] r;
      r = cur;
      if (cur < tgt) begin
         r = cur + 7'd1;
      end else if (cur > tgt) begin
         r = cur - 7'd1;
      end
      return r;
   endfunction

   function automatic state_s reset_state();
      state_s s;
      s = '0;
      for (int i = 0; i < NRW; i++) begin
         s.rw[i] = RW_RST[i];
      end
      for (int c = 0; c < NACT; c++) begin
         s.act[c] = ACT_RST[c];
      end
      return s;
   endfunction

   logic [7:0]         ctrl_of [NACT];
   logic [6:0]         tgt_of  [NACT];
   logic               bias_on;
   logic               guard_on;
   logic               above_thr;
   logic [LEVEL_W:0]   thr_level;
   logic [5:0]         clip_sum;

   always_comb begin
      nxt_state = state_ff;
      bias_on   = state_ff.rw[IX_REFS][B_BIAS_EN];
      guard_on  = state_ff.rw[IX_ALC_CTRL][B_ALC_EN] &&
                  state_ff.rw[IX_CLIP_CTRL][B_CLIP_EN];
      thr_level = (LEVEL_W+1)'({1'b0, state_ff.rw[IX_CLIP_LEVEL][6:0]}
                  + 8'd1) << THR_SHIFT;
      above_thr = {1'b0, adc_level} > thr_level;
      clip_sum  = 6'(state_ff.clip_acc) +
                  (6'd1 << state_ff.rw[IX_CLIP_CTRL][1:0]);

      // register writes; read-only and unmapped offsets fall through
      if (wr_en) begin
         for (int i = 0; i < NRW; i++) begin
            if (addr == RW_OFS[i]) begin
               nxt_state.rw[i] = wdata & RW_MASK[i];
            end
         end
         if (addr == REG_CLIP_LEVEL) begin
            nxt_state.rw[IX_CLIP_LEVEL] = wdata & MASK_CLIP_LEVEL;
         end
         // reserved source code would leave the input undefined
         if (addr == RW_OFS[IX_MIC_SEL] &&
             wdata[1:0] == MIC_SRC_RESERVED) begin
            nxt_state.rw[IX_MIC_SEL] = state_ff.rw[IX_MIC_SEL];
         end
      end

      // clip guard lowers the adc gain only while level control is on
      if (!guard_on) begin
         nxt_state.clip_atten = '0;
         nxt_state.clip_acc   = '0;
      end else if (sample_tick && above_thr) begin
         if (clip_sum >= 6'(CLIP_UNITS_PER_CODE)) begin
            nxt_state.clip_acc = 5'(clip_sum - 6'(CLIP_UNITS_PER_CODE));
            if (state_ff.clip_atten < state_ff.rw[IX_ADC_GAIN][6:0]) begin
               nxt_state.clip_atten = state_ff.clip_atten + 7'd1;
            end
         end else begin
            nxt_state.clip_acc = 5'(clip_sum);
         end
      end

      // active gain follows its gain field while the path is on
      for (int c = 0; c < NACT; c++) begin
         ctrl_of[c] = state_ff.rw[ACT_CTRL_IX[c]];
         tgt_of[c]  = state_ff.rw[ACT_GAIN_IX[c]][6:0];
         if (c == CH_ADC) begin
            tgt_of[c] = tgt_of[c] - state_ff.clip_atten;
         end
         if ((c == CH_HPL || c == CH_HPR) && ctrl_of[c][B_MIN_GAIN]) begin
            tgt_of[c] = '0;
         end
         if (ctrl_of[c][B_EN] && bias_on) begin
            if (!ctrl_of[c][B_RAMP]) begin
               nxt_state.act[c] = tgt_of[c];
            end else if (sample_tick) begin
               nxt_state.act[c] = step_to(state_ff.act[c], tgt_of[c]);
            end
         end
      end

      nxt_state.ofs = offset_value;

      // read path, one cycle after the strobe
      nxt_state.rvalid = rd_en;
      if (rd_en) begin
         nxt_state.rdata = '0;
         for (int i = 0; i <= NRW; i++) begin
            if (addr == (i == NRW ? REG_CLIP_LEVEL : RW_OFS[i])) begin
               nxt_state.rdata = state_ff.rw[i];
            end
         end
         for (int c = 0; c < NACT; c++) begin
            if (addr == ACT_OFS[c]) begin
               nxt_state.rdata = {1'b0, state_ff.act[c]};
            end
         end
         if (addr == REG_OFS_MID) begin
            nxt_state.rdata = state_ff.ofs[15:8];
         end
         if (addr == REG_OFS_UPPER) begin
            nxt_state.rdata = {4'h0, state_ff.ofs[19:16]};
         end
      end

      // analog controls; master bias off takes every path down
      nxt_state.ctl.mic_en        = bias_on && ctrl_of[CH_MIC][B_EN];
      nxt_state.ctl.mic_mute      = ctrl_of[CH_MIC][B_MUTE];
      nxt_state.ctl.mic_src       = state_ff.rw[IX_MIC_SEL][1:0];
      nxt_state.ctl.mic_gain      = state_ff.act[CH_MIC][2:0];
      nxt_state.ctl.micbias_en    = bias_on &&
                                    state_ff.rw[IX_MICBIAS][B_MICB_EN];
      nxt_state.ctl.micbias_level = state_ff.rw[IX_MICBIAS][2:0];
      nxt_state.ctl.vmid_fast     =
         state_ff.rw[IX_REFS][B_VMID_FAST];
      nxt_state.ctl.bias_en       = bias_on;
      nxt_state.ctl.mixin_en      = bias_on &&
                                    state_ff.rw[IX_MIXIN_CTRL][B_EN];
      nxt_state.ctl.mixin_mute    = state_ff.rw[IX_MIXIN_CTRL][B_MUTE];
      nxt_state.ctl.mixin_mic_sel = state_ff.rw[IX_MIXIN_CTRL][B_MIX_EN]
                                 && state_ff.rw[IX_MIXIN_SEL][B_SEL];
      nxt_state.ctl.mixin_gain    = state_ff.act[1][3:0];
      nxt_state.ctl.adc_en        = bias_on && ctrl_of[CH_ADC][B_EN];
      nxt_state.ctl.adc_mute      = ctrl_of[CH_ADC][B_MUTE];
      nxt_state.ctl.adc_gain      = state_ff.act[CH_ADC];
      for (int d = 0; d < 2; d++) begin
         nxt_state.ctl.dac_en[d]   = bias_on && ctrl_of[3+d][B_EN];
         nxt_state.ctl.dac_mute[d] = ctrl_of[3+d][B_MUTE] ||
                                     state_ff.act[3+d] <= DAC_MUTE_TOP;
         nxt_state.ctl.phones_en[d]    = bias_on && ctrl_of[5+d][B_EN];
         nxt_state.ctl.phones_mute[d]  = ctrl_of[5+d][B_MUTE];
         nxt_state.ctl.phones_drive[d] = ctrl_of[5+d][B_OE];
         nxt_state.ctl.mixout_en[d]    =
            bias_on && state_ff.rw[IX_MOUTL_CTRL+d][B_EN];
         nxt_state.ctl.mixout_dac_sel[d] =
            state_ff.rw[IX_MOUTL_SEL+d][B_SEL];
      end
      nxt_state.ctl.dac_l_gain             = state_ff.act[3];
      nxt_state.ctl.dac_r_gain             = state_ff.act[4];
      nxt_state.ctl.left_phones_gain_code  = state_ff.act[CH_HPL][5:0];
      nxt_state.ctl.right_phones_gain_code = state_ff.act[CH_HPR][5:0];
      nxt_state.ctl.io_low_range = state_ff.rw[IX_IO][B_IO_RANGE];
   end

   // ce low freezes every flop, including the read answer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= reset_state();
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   assign rdata  = state_ff.rdata;
   assign rvalid = state_ff.rvalid;
   assign ctl    = state_ff.ctl;

endmodule

// file: audio_path_gain_routing_regs_properties.sv
// concurrent checks on the ports of the audio path register bank
// assumes one clock domain and the registered read port of the bank
`timescale 1ns/100ps
module audio_path_gain_routing_regs_properties
   import audio_regs_pkg::*;
#(
   parameter int LEVEL_W = 16  // level sample width
) (
   input wire logic                         clk,          // clock
   input wire logic                         rst,          // async reset
   input wire logic                         ce,           // clock enable
   input wire logic                         wr_en,        // write strobe
   input wire logic                         rd_en,        // read strobe
   input wire logic [audio_regs_pkg::ADDR_W-1:0] addr,    // register
   input wire logic [audio_regs_pkg::DATA_W-1:0] wdata,   // write data
   input wire logic [audio_regs_pkg::DATA_W-1:0] rdata,   // read data
   input wire logic                         rvalid,       // read done
   input wire logic                         sample_tick,  // one per Fs
   input wire logic [LEVEL_W-1:0]           adc_level,    // |output|
   input wire logic [19:0]                  offset_value, // dc offset
   input wire audio_regs_pkg::analog_ctrl_s ctl           // to analog
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_read_answer:
      assert property (ce && rd_en |=> rvalid)
      else $error("read strobe gave no valid");
   a_valid_pulse:
      assert property (ce && !rd_en |=> !rvalid)
      else $error("valid without a read");
   a_unmapped_zero:
      assert property (ce && rd_en && addr == 8'hFF |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_offset_mid:
      assert property (!$past(rst) && ce && rd_en && addr == REG_OFS_MID
         && $stable(offset_value) |=> rdata == $past(offset_value[15:8]))
      else $error("offset middle byte wrong");
   a_offset_upper:
      assert property (!$past(rst) && ce && rd_en && addr == REG_OFS_UPPER
         && $stable(offset_value)
         |=> rdata == {4'h0, $past(offset_value[19:16])})
      else $error("offset upper nibble wrong");
   a_adc_gain_store:
      assert property (ce && wr_en && addr == 8'h36 ##1 !wr_en
         ##1 ce && rd_en && addr == 8'h36
         |=> rdata == {1'b0, $past(wdata[6:0], 3)})
      else $error("adc gain not stored");
   a_reserved_src:
      assert property (ce && wr_en && addr == 8'h10
         && wdata[1:0] == MIC_SRC_RESERVED |=> ##1 $stable(ctl.mic_src))
      else $error("reserved source code taken");
   a_mute_low_code:
      assert property (!$past(rst)
         |-> (ctl.dac_l_gain > DAC_MUTE_TOP || ctl.dac_mute[0])
         && (ctl.dac_r_gain > DAC_MUTE_TOP || ctl.dac_mute[1]))
      else $error("low dac code not muted");
   a_bias_gates:
      assert property (!ctl.bias_en |-> ctl.dac_en == 2'b00
         && !ctl.adc_en && ctl.phones_en == 2'b00)
      else $error("path enabled without bias");

   c_clip_on: cover property (ce && wr_en && addr == 8'hA1 && wdata[7]);
   c_dac_muted: cover property (ctl.dac_mute[0] && ctl.dac_en[0]);
   c_atten_read: cover property (rvalid && rdata == 8'h6E);
endmodule

// file: audio_path_gain_routing_regs_test.sv
// self-checking bench for the audio path register bank
// assumes the bank package and the property checker compile first
`timescale 1ns/100ps
`define CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module audio_path_gain_routing_regs_test;
   import audio_regs_pkg::*;
   localparam int LEVEL_W = 16;
   // address and expected value packed together
   // last entry is an unmapped offset, which must read zero
   localparam logic [15:0] RST_T [24] = '{16'h0601, 16'h0800, 16'h0A00,
      16'h0C00, 16'h0D00, 16'h0E00, 16'h0F00, 16'h1000, 16'h3208,
      16'h3300, 16'h3403, 16'h366F, 16'h3901, 16'h456F, 16'h466F,
      16'h4839, 16'h4939, 16'h4B00, 16'h4C00, 16'hA100, 16'hA200,
      16'hA300, 16'hA400, 16'hFF00};
   // address, written value, value read back
   localparam logic [23:0] WR_T [16] = '{24'h10_FE02, 24'h32_FF18,
      24'h33_FF01, 24'h34_FF0F, 24'h36_FF7F, 24'h39_FF07, 24'h45_FF7F,
      24'h46_8000, 24'h48_FF3F, 24'h49_C000, 24'h4B_FF01, 24'h4C_FE00,
      24'hA2_FF7F, 24'hA1_FF83, 24'h0A_FF00, 24'hA4_FF00};
   logic               clk;
   logic               rst;
   logic               ce;
   logic               wr_en;
   logic               rd_en;
   logic               sample_tick;
   logic               rvalid;
   logic [7:0]         addr;
   logic [7:0]         wdata;
   logic [7:0]         rdata;
   logic [7:0]         got;
   logic [LEVEL_W-1:0] adc_level;
   logic [19:0]        offset_value;
   analog_ctrl_s       ctl;
   int                 fails = 0;
   int                 checks = 0;
   int                 cycles = 0;

   audio_path_gain_routing_regs #(.LEVEL_W(LEVEL_W)) i_dut (
      .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
      .sample_tick(sample_tick), .adc_level(adc_level),
      .offset_value(offset_value), .ctl(ctl));

   task automatic conclude();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // fixed one-cycle answer, so no wait loop is needed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      `CHK(rvalid, 1'b1)
      d = rdata;
   endtask

   task automatic tick(input logic [15:0] lvl);
      @(posedge clk);
      adc_level   <= lvl;
      sample_tick <= 1'b1;
      @(posedge clk);
      sample_tick <= 1'b0;
   endtask

   task automatic t_reset();
      for (int i = 0; i < 24; i++) begin
         rd(RST_T[i][15:8], got);
         `CHK(got, RST_T[i][7:0])
      end
      $display("done reset values");
   endtask

   task automatic t_masks();
      for (int i = 0; i < 16; i++) begin
         wr(WR_T[i][23:16], WR_T[i][15:8]);
         rd(WR_T[i][23:16], got);
         `CHK(got, WR_T[i][7:0])
      end
      $display("done field masks");
   endtask

   task automatic t_mic_src();
      for (int c = 0; c < 4; c++) begin
         wr(8'h10, 8'(c));
         rd(8'h10, got);
         `CHK(got, (c == 3) ? 8'h02 : 8'(c))
      end
      `CHK(ctl.mic_src, 2'h2)
      $display("done mic source");
   endtask

   task automatic t_offset();
      @(posedge clk);
      offset_value <= 20'hA_B5C3;
      wr(8'hA3, 8'h00);
      rd(8'hA3, got);
      `CHK(got, 8'hB5)
      rd(8'hA4, got);
      `CHK(got, 8'h0A)
      $display("done offset readback");
   endtask

   task automatic t_gain();
      wr(8'h45, 8'h05);
      wr(8'h69, 8'h80);
      repeat (2) @(posedge clk);
      rd(8'h0C, got);
      `CHK(got, 8'h05)
      `CHK(ctl.dac_mute[0], 1'b1)
      wr(8'h45, 8'h08);
      rd(8'h0C, got);
      `CHK(got, 8'h08)
      repeat (2) @(posedge clk);
      `CHK(ctl.dac_mute[0], 1'b0)
      wr(8'h32, 8'h00);
      wr(8'h45, 8'h40);
      rd(8'h0C, got);
      `CHK(got, 8'h08)
      `CHK(ctl.dac_en[0], 1'b0)
      wr(8'h32, 8'h08);
      wr(8'h63, 8'h80);
      wr(8'h6B, 8'h80);
      wr(8'h65, 8'h08);
      repeat (2) @(posedge clk);
      rd(8'h06, got);
      `CHK(got, 8'h07)
      rd(8'h0E, got);
      `CHK(got, 8'h3F)
      `CHK(ctl.mixin_mic_sel, 1'b1)
      `CHK(ctl.mixout_dac_sel, 2'b01)
      $display("done active gain");
   endtask

   task automatic t_clip();
      wr(8'h2F, 8'h08);
      wr(8'hA2, 8'h00);
      wr(8'hA1, 8'h03);
      wr(8'h36, 8'h6F);
      wr(8'h67, 8'h80);
      repeat (3) tick(16'h0201);
      rd(8'h0A, got);
      `CHK(got, 8'h6F)
      wr(8'hA1, 8'h83);
      repeat (3) tick(16'h0200);
      rd(8'h0A, got);
      `CHK(got, 8'h6F)
      repeat (3) tick(16'h0201);
      repeat (2) @(posedge clk);
      rd(8'h0A, got);
      `CHK(got, 8'h6E)
      `CHK(ctl.adc_gain, 7'h6E)
      wr(8'h2F, 8'h00);
      repeat (2) @(posedge clk);
      rd(8'h0A, got);
      `CHK(got, 8'h6F)
      $display("done clip guard");
   endtask

   // a write strobed while ce is low must not land
   task automatic t_freeze();
      @(posedge clk);
      ce <= 1'b0;
      wr(8'h36, 8'h01);
      @(posedge clk);
      ce <= 1'b1;
      rd(8'h36, got);
      `CHK(got, 8'h6F)
      $display("done clock enable");
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // whole run is well under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end

   initial begin
      rst          = 1'b1;
      ce           = 1'b1;
      wr_en        = 1'b0;
      rd_en        = 1'b0;
      addr         = 8'h00;
      wdata        = 8'h00;
      sample_tick  = 1'b0;
      adc_level    = 16'h0000;
      offset_value = 20'h0_0000;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_masks();
      t_mic_src();
      t_offset();
      t_gain();
      t_clip();
      t_freeze();
      conclude();
   end
endmodule

bind audio_path_gain_routing_regs audio_path_gain_routing_regs_properties #(
   .LEVEL_W(LEVEL_W)
) i_props (
   .clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en), .rd_en(rd_en),
   .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
   .sample_tick(sample_tick), .adc_level(adc_level),
   .offset_value(offset_value), .ctl(ctl));

// file: audio_regs_pkg.sv
// register map, field layout and reset values for the audio path bank
// assumes one 8-bit register port in the system clock domain
package audio_regs_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // read/write registers, index order of the tables below
   localparam int NRW           = 25;
   localparam int IX_MIC_SEL    = 0;
   localparam int IX_REFS       = 1;
   localparam int IX_MIXIN_SEL  = 2;
   localparam int IX_MIXIN_GAIN = 3;
   localparam int IX_ADC_GAIN   = 4;
   localparam int IX_MIC_GAIN   = 5;
   localparam int IX_DACL_GAIN  = 6;
   localparam int IX_DACR_GAIN  = 7;
   localparam int IX_HPL_GAIN   = 8;
   localparam int IX_HPR_GAIN   = 9;
   localparam int IX_MOUTL_SEL  = 10;
   localparam int IX_MOUTR_SEL  = 11;
   localparam int IX_MICBIAS    = 12;
   localparam int IX_MIC_CTRL   = 13;
   localparam int IX_MIXIN_CTRL = 14;
   localparam int IX_ADC_CTRL   = 15;
   localparam int IX_DACL_CTRL  = 16;
   localparam int IX_DACR_CTRL  = 17;
   localparam int IX_HPL_CTRL   = 18;
   localparam int IX_HPR_CTRL   = 19;
   localparam int IX_MOUTL_CTRL = 20;
   localparam int IX_MOUTR_CTRL = 21;
   localparam int IX_IO         = 22;
   localparam int IX_ALC_CTRL   = 23;
   localparam int IX_CLIP_CTRL  = 24;

   localparam logic [7:0] RW_OFS [NRW] = '{
      8'h10, 8'h32, 8'h33, 8'h34, 8'h36, 8'h39, 8'h45, 8'h46, 8'h48,
      8'h49, 8'h4B, 8'h4C, 8'h62, 8'h63, 8'h65, 8'h67, 8'h69, 8'h6A,
      8'h6B, 8'h6C, 8'h6E, 8'h6F, 8'h91, 8'h2F, 8'hA1};
   localparam logic [7:0] RW_MASK [NRW] = '{
      8'h03, 8'h18, 8'h01, 8'h0F, 8'h7F, 8'h07, 8'h7F, 8'h7F, 8'h3F,
      8'h3F, 8'h01, 8'h01, 8'h0F, 8'hE0, 8'hF8, 8'hE0, 8'hE0, 8'hE0,
      8'hFC, 8'hFC, 8'h80, 8'h80, 8'h01, 8'h08, 8'h83};
   localparam logic [7:0] RW_RST [NRW] = '{
      8'h00, 8'h08, 8'h00, 8'h03, 8'h6F, 8'h01, 8'h6F, 8'h6F, 8'h39,
      8'h39, 8'h00, 8'h00, 8'h03, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40,
      8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   // threshold register sits apart: it is a plain 7-bit field
   localparam int IX_CLIP_LEVEL = NRW;
   localparam logic [7:0] REG_CLIP_LEVEL  = 8'hA2;
   localparam logic [7:0] MASK_CLIP_LEVEL = 8'h7F;
   localparam logic [7:0] REG_OFS_MID     = 8'hA3;
   localparam logic [7:0] REG_OFS_UPPER   = 8'hA4;

   // gain channels with an active-gain readback
   localparam int NACT = 7;
   localparam int CH_MIC = 0;
   localparam int CH_ADC = 2;
   localparam int CH_HPL = 5;
   localparam int CH_HPR = 6;
   localparam logic [7:0] ACT_OFS [NACT] = '{
      8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
   localparam logic [6:0] ACT_RST [NACT] = '{
      7'h01, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
   localparam int ACT_GAIN_IX [NACT] = '{
      IX_MIC_GAIN, IX_MIXIN_GAIN, IX_ADC_GAIN, IX_DACL_GAIN,
      IX_DACR_GAIN, IX_HPL_GAIN, IX_HPR_GAIN};
   localparam int ACT_CTRL_IX [NACT] = '{
      IX_MIC_CTRL, IX_MIXIN_CTRL, IX_ADC_CTRL, IX_DACL_CTRL,
      IX_DACR_CTRL, IX_HPL_CTRL, IX_HPR_CTRL};

   // field positions
   localparam int B_EN        = 7;
   localparam int B_MUTE      = 6;
   localparam int B_RAMP      = 5;
   localparam int B_OE        = 3;
   localparam int B_MIN_GAIN  = 2;
   localparam int B_MIX_EN    = 3;
   localparam int B_SEL       = 0;
   localparam int B_VMID_FAST = 4;
   localparam int B_BIAS_EN   = 3;
   localparam int B_MICB_EN   = 3;
   localparam int B_ALC_EN    = 3;
   localparam int B_CLIP_EN   = 7;
   localparam int B_IO_RANGE  = 0;

   localparam logic [1:0] MIC_SRC_RESERVED = 2'h3;
   localparam logic [6:0] DAC_MUTE_TOP     = 7'h07;
   localparam int         THR_SHIFT        = 9;

   // clip attack counts in units of 0.034 dB; one gain code is 0.75 dB
   localparam int         CLIP_UNIT_MDB  = 34;
   localparam int         GAIN_STEP_MDB  = 750;
   localparam logic [4:0] CLIP_UNITS_PER_CODE =
      5'(GAIN_STEP_MDB / CLIP_UNIT_MDB);

   typedef struct packed {
      logic       mic_en;
      logic       mic_mute;
      logic [1:0] mic_src;
      logic [2:0] mic_gain;
      logic       micbias_en;
      logic [2:0] micbias_level;
      logic       vmid_fast;
      logic       bias_en;
      logic       mixin_en;
      logic       mixin_mute;
      logic       mixin_mic_sel;
      logic [3:0] mixin_gain;
      logic       adc_en;
      logic       adc_mute;
      logic [6:0] adc_gain;
      logic [1:0] dac_en;
      logic [1:0] dac_mute;
      logic [6:0] dac_l_gain;
      logic [6:0] dac_r_gain;
      logic [1:0] phones_en;
      logic [1:0] phones_mute;
      logic [1:0] phones_drive;
      logic [5:0] left_phones_gain_code;
      logic [5:0] right_phones_gain_code;
      logic [1:0] mixout_en;
      logic [1:0] mixout_dac_sel;
      logic       io_low_range;
   } analog_ctrl_s;

endpackage
